/* File: bnx_branch_if_no_overflow.sv */
`timescale 1ns/1ps
// Behaviour
// - Branch taken only when overflow flag is 0, else fall through.
// - Offset is signed 8-bit, doubled, added to program counter.
// - Target is branch address plus 2 plus twice the offset.
// - One cycle when not taken; taken adds a flushing no-op cycle.
module bnx_branch_if_no_overflow (
   input  wire logic                         clk_sys,
   input  wire logic                         rst,
   input  wire logic                         instr_valid,
   input  wire logic [bnx_pkg::INSTR_W-1:0]  instr,
   input  wire logic [bnx_pkg::PC_W-1:0]     pc_in,
   input  wire logic                         ovf_flag,
   output logic      [bnx_pkg::PC_W-1:0]     program_counter,
   output logic                              pc_load,
   output logic                              flush,
   output logic                              busy,
   output logic                              done,
   output logic      [1:0]                   q_phase
);
   import bnx_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   // Phase sequencer
   bnx_phase_t        ph_q, ph_d;
   logic              in_q1, in_q2, in_q3, in_q4; // One-hot phase strobes

   // Execution control
   logic              act_q, act_d;        // Executing a first cycle
   logic              taken_q, taken_d;    // Branch condition result
   logic              nop_q, nop_d;        // Second, no-op cycle
   logic [OFS_W-1:0]  ofs_q, ofs_d;        // Latched signed offset
   logic [PC_W-1:0]   pcadv_q, pcadv_d;    // Counter advanced past branch

   // Results towards the core
   logic [PC_W-1:0]   pc_q, pc_d;
   logic              load_q, load_d;
   logic              flush_q, flush_d;
   logic              done_q, done_d;
   logic              busy_q, busy_d;

   // Combinational helpers
   logic [PC_W-1:0]   target;
   logic              hit;
   logic              accept;
   logic              finish_first;        // Q4 of an executing first cycle
   logic              finish_nop;          // Q4 of the no-op cycle

   // ------------------------------------------------------------
   // Phase decode
   // ------------------------------------------------------------
   // One strobe per phase of the instruction cycle
   assign in_q1 = (ph_q == BNX_Q1);
   assign in_q2 = (ph_q == BNX_Q2);
   assign in_q3 = (ph_q == BNX_Q3);
   assign in_q4 = (ph_q == BNX_Q4);

   // ------------------------------------------------------------
   // Opcode decode
   // ------------------------------------------------------------
   // Upper byte selects this branch, lower byte is the offset
   assign hit = instr_valid && (instr[INSTR_W-1:OPC_HI_POS] == OPC_BRANCH_NOV);

   // Accept only at a free Q1, requests while busy are dropped
   assign accept = in_q1 && !act_q && !nop_q && hit;

   // End of the first cycle and of the no-op cycle
   assign finish_first = in_q4 && act_q;
   assign finish_nop   = in_q4 && nop_q;

   // ------------------------------------------------------------
   // Target adder
   // ------------------------------------------------------------
   // Doubled signed offset added to the advanced counter
   bnx_target i_bnx_target (
      .pc_adv (pcadv_q),
      .offset (ofs_q),
      .target (target)
   );

   // ------------------------------------------------------------
   // Phase sequencer
   // ------------------------------------------------------------
   // Next phase, Gray order Q1 Q2 Q3 Q4 and back
   always_comb begin
      ph_d = ph_q;
      case (ph_q)
         BNX_Q1: begin
            ph_d = BNX_Q2;
         end
         BNX_Q2: begin
            ph_d = BNX_Q3;
         end
         BNX_Q3: begin
            ph_d = BNX_Q4;
         end
         BNX_Q4: begin
            ph_d = BNX_Q1;
         end
         default: begin
            ph_d = BNX_Q1;
         end
      endcase
   end

   // Phase register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ph_q <= BNX_Q1;
      end else begin
         ph_q <= ph_d;
      end
   end

   // ------------------------------------------------------------
   // Execution control
   // ------------------------------------------------------------
   // Next execution state per phase
   always_comb begin
      act_d   = act_q;
      taken_d = taken_q;
      nop_d   = nop_q;
      ofs_d   = ofs_q;
      pcadv_d = pcadv_q;
      case (ph_q)
         BNX_Q1: begin
            if (accept) begin
               act_d   = 1'b1;
               pcadv_d = pc_in + PC_STEP;
            end
         end
         BNX_Q2: begin
            if (act_q) begin
               ofs_d = instr[OFS_W-1:0];
            end
         end
         BNX_Q3: begin
            if (act_q) begin
               taken_d = ~ovf_flag;
            end
         end
         BNX_Q4: begin
            if (act_q) begin
               act_d = 1'b0;
               nop_d = taken_q;
            end else if (nop_q) begin
               nop_d = 1'b0;
            end
         end
         default: begin
            act_d = 1'b0;
            nop_d = 1'b0;
         end
      endcase
   end

   // Execution registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         act_q   <= 1'b0;
         taken_q <= 1'b0;
         nop_q   <= 1'b0;
         ofs_q   <= '0;
         pcadv_q <= PC_RESET;
      end else begin
         act_q   <= act_d;
         taken_q <= taken_d;
         nop_q   <= nop_d;
         ofs_q   <= ofs_d;
         pcadv_q <= pcadv_d;
      end
   end

   // ------------------------------------------------------------
   // Results
   // ------------------------------------------------------------
   // Counter load, flush and completion strobes; flags never written
   always_comb begin
      pc_d    = pc_q;
      load_d  = 1'b0;
      flush_d = 1'b0;
      done_d  = 1'b0;
      busy_d  = act_d | nop_d;
      if (finish_first) begin
         load_d = 1'b1;
         if (taken_q) begin
            pc_d = target;
         end else begin
            pc_d   = pcadv_q;
            done_d = 1'b1;
         end
      end else if (finish_nop) begin
         flush_d = 1'b1;
         done_d  = 1'b1;
      end
   end

   // Result registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pc_q    <= PC_RESET;
         load_q  <= 1'b0;
         flush_q <= 1'b0;
         done_q  <= 1'b0;
         busy_q  <= 1'b0;
      end else begin
         pc_q    <= pc_d;
         load_q  <= load_d;
         flush_q <= flush_d;
         done_q  <= done_d;
         busy_q  <= busy_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Every output straight from a flip-flop
   assign program_counter = pc_q;
   assign pc_load         = load_q;
   assign flush           = flush_q;
   assign busy            = busy_q;
   assign done            = done_q;
   assign q_phase         = ph_q;
endmodule // bnx_branch_if_no_overflow

/* File: bnx_pkg.sv */
package bnx_pkg;
   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int PC_W    = 21;
   localparam int INSTR_W = 16;
   localparam int OFS_W   = 8;

   // ------------------------------------------------------------
   // Encoding
   // ------------------------------------------------------------
   localparam logic [7:0] OPC_BRANCH_NOV = 8'hE5;
   localparam int         OPC_HI_POS     = 8;

   // ------------------------------------------------------------
   // Timing and reset values
   // ------------------------------------------------------------
   localparam logic [PC_W-1:0] PC_STEP       = 21'h0_0002;
   localparam logic [PC_W-1:0] PC_RESET      = 21'h0_0000;
   localparam logic [1:0]      Q_LAST        = 2'h3;
   localparam logic [1:0]      Q_RESET       = 2'h0;

   // Execution phase state, Gray along Q1..Q4
   typedef enum logic [1:0] {
      BNX_Q1 = 2'b00,
      BNX_Q2 = 2'b01,
      BNX_Q3 = 2'b11,
      BNX_Q4 = 2'b10
   } bnx_phase_t;
endpackage

/* File: bnx_target.sv */
`timescale 1ns/1ps
module bnx_target (
   input  wire logic [bnx_pkg::PC_W-1:0]  pc_adv,
   input  wire logic [bnx_pkg::OFS_W-1:0] offset,
   output logic      [bnx_pkg::PC_W-1:0]  target
);
   import bnx_pkg::*;

   logic [PC_W-1:0] ofs_ext;

   // Sign extend and double the offset, add to advanced counter
   always_comb begin
      ofs_ext = {{(PC_W-OFS_W-1){offset[OFS_W-1]}}, offset, 1'b0};
      target  = pc_adv + ofs_ext;
   end
endmodule // bnx_target

/* File: bnx_chk_assertions.sv */
`timescale 1ns/1ps
module bnx_chk (
   input wire logic                        clk_sys,
   input wire logic                        rst,
   input wire logic                        instr_valid,
   input wire logic [bnx_pkg::INSTR_W-1:0] instr,
   input wire logic [bnx_pkg::PC_W-1:0]    pc_in,
   input wire logic                        ovf_flag,
   input wire logic [bnx_pkg::PC_W-1:0]    program_counter,
   input wire logic                        pc_load,
   input wire logic                        flush,
   input wire logic                        busy,
   input wire logic                        done,
   input wire logic [1:0]                  q_phase
);
   import bnx_pkg::*;
   logic [PC_W-1:0] exp_fall_q, exp_jump_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Accepted branch at a free Q1
   sequence s_take;
      q_phase == 2'h0 && instr_valid && instr[15:8] == OPC_BRANCH_NOV && !busy;
   endsequence
   sequence s_gray;
      q_phase == 2'h1 ##1 q_phase == 2'h3 ##1 q_phase == 2'h2 ##1 q_phase == 2'h0;
   endsequence
   // Expected counter captured at acceptance
   always_ff @(posedge clk_sys) begin
      if (q_phase == 2'h0 && !busy) begin
         exp_fall_q <= pc_in + PC_STEP;
         exp_jump_q <= pc_in + PC_STEP + {{12{instr[7]}}, instr[7:0], 1'b0};
      end
   end
   AST_FALL:
   assert property (s_take ##2 ovf_flag |-> ##2 pc_load && done && !busy
      && program_counter == exp_fall_q) else $error("fall through wrong");
   AST_JUMP:
   assert property (s_take ##2 !ovf_flag |-> ##2 pc_load && !done && busy
      && program_counter == exp_jump_q) else $error("branch target wrong");
   AST_BUSY:
   assert property (s_take |=> busy [*3]) else $error("busy dropped early");
   AST_NOP:
   assert property (pc_load && !done |=> !flush [*3] ##1 flush && done && !busy)
      else $error("no-op cycle wrong");
   AST_PULSE:
   assert property (pc_load |=> !pc_load) else $error("load not a pulse");
   AST_PHASE:
   assert property (q_phase == 2'h0 |=> s_gray) else $error("phase order wrong");
   AST_REFUSE:
   assert property (q_phase == 2'h0 && instr_valid && instr[15:8] != OPC_BRANCH_NOV && !busy
      |=> !pc_load [*5]) else $error("other opcode acted on");
endmodule // bnx_chk
bind bnx_branch_if_no_overflow bnx_chk i_bnx_chk (.*);

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
   import bnx_pkg::*;
   logic               clk_sys = 0, rst = 1, instr_valid = 0, ovf_flag = 0;
   logic [INSTR_W-1:0] instr = 16'h0000;
   logic [PC_W-1:0]    pc_in = 21'h0_0000, program_counter;
   logic               pc_load, flush, busy, done;
   logic [1:0]         q_phase;
   int                 n_fail = 0, total_checks = 0, cyc = 0, w;
   // Clock and hang guard
   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (++cyc == 2000) begin
      n_fail++;
      conclude();
   end
   bnx_branch_if_no_overflow i_bnx_branch_if_no_overflow (.*);
   task automatic check(input logic [PC_W-1:0] seen, input logic [PC_W-1:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Offer one word at a free Q1, wait for the counter load
   task automatic exec(input logic [7:0] opc, input logic [7:0] ofs, input logic ovf);
      while (q_phase !== 2'h0 || busy !== 1'b0) @(negedge clk_sys);
      instr = {opc, ofs};
      instr_valid = 1;
      ovf_flag = ovf;
      @(negedge clk_sys);
      instr_valid = 0;
      w = 0;
      while (pc_load !== 1'b1 && w < 12) begin
         @(negedge clk_sys);
         w++;
      end
   endtask
   task automatic t_fall(input logic [PC_W-1:0] pc);
      pc_in = pc;
      exec(OPC_BRANCH_NOV, 8'h7F, 1'b1);
      check(21'(w), 21'h0_0003);
      check(program_counter, pc + 21'h0_0002);
      check(21'(done), 21'h0_0001);
      check(21'(busy), 21'h0_0000);
      check(21'(q_phase), 21'h0_0000);
      $display("test fall through ended");
   endtask
   task automatic t_jump(input logic [7:0] ofs, input logic [PC_W-1:0] pc, exp);
      pc_in = pc;
      exec(OPC_BRANCH_NOV, ofs, 1'b0);
      check(program_counter, exp);
      check(21'(done), 21'h0_0000);
      check(21'(busy), 21'h0_0001);
      w = 0;
      while (flush !== 1'b1 && w < 12) begin
         @(negedge clk_sys);
         w++;
      end
      check(21'(w), 21'h0_0004);
      check(21'(done), 21'h0_0001);
      check(21'(busy), 21'h0_0000);
      $display("test branch taken ended");
   endtask
   task automatic t_refuse;
      exec(8'hE7, 8'h10, 1'b0);
      check(21'(w), 21'h0_000C);
      $display("test other opcode ended");
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (2) @(negedge clk_sys);
      rst = 0;
      t_fall(21'h0_1000);
      t_fall(21'h0_2000);
      t_jump(8'h80, 21'h0_1000, 21'h0_0F02);
      t_jump(8'h7F, 21'h1F_FFF0, 21'h0_00F0);
      t_refuse();
      conclude();
   end
endmodule // tb
